// File: rtl/sync_slave_serial_transmit.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The lockstep mode select bit at 1 makes the unit shift data against a clock.
// - The clock source select bit at 0 makes the unit a slave taking the external strobe.
// - With both receive enables at 0 the unit transmits; either one set selects receive.
// - The unit operates only while the serial port enable bit is 1.
// - Slave transmission shifts exactly as master transmission does, clocked from outside.
// - With two words written before Sleep, the first moves to the shift register at once.
// - The second word stays held and the transmit buffer flag stays clear meanwhile.
// - After the first word leaves, the held word moves to the shift register and the flag sets.
// - A flag set with peripheral and transmit interrupt enables at 1 wakes from Sleep.
// - With the global interrupt enable also 1, the wake-up also branches to the service routine.
// - With the ninth-bit enable set, words are 9 bits and the ninth-bit value is the top bit.
// - Transmission happens only once the transmit enable bit is set.
// - Writing the low eight data bits starts a transmission, after the ninth-bit value.
module sync_slave_serial_transmit (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [sst_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [sst_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [sst_pkg::DATA_W-1:0] reg_rdata_out,
  output logic hold_ready_out,
  input wire logic serial_strobe_pin_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic wake_out,
  output logic isr_branch_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_e;

  shift_state_e state_ff;
  shift_state_e nxt_state;
  logic [sst_pkg::DATA_W-1:0] tx_ctrl_ff;
  logic [sst_pkg::DATA_W-1:0] rx_ctrl_ff;
  logic [sst_pkg::WORD_W-1:0] hold_ff;
  logic hold_full_ff;
  logic [sst_pkg::WORD_W-1:0] shift_ff;
  logic [sst_pkg::CNT_W-1:0] bits_left_ff;
  logic ninth_len_ff;
  logic buffer_flag_ff;
  logic tx_irq_en_ff;
  logic periph_irq_en_ff;
  logic global_irq_en_ff;
  logic sleep_ff;
  logic wake_ff;
  logic isr_ff;
  logic [sst_pkg::DATA_W-1:0] rdata_ff;
  logic strobe_rise;
  logic strobe_fall;
  logic tx_active;
  logic last_bit;
  logic move_to_shift;
  logic hold_load;
  logic hold_write;
  logic flag_set;
  logic wake_now;
  logic [sst_pkg::CNT_W-1:0] queued_ff;

  stream_if #(.WIDTH(sst_pkg::WORD_W)) push_if ();
  stream_if #(.WIDTH(sst_pkg::WORD_W)) pop_if ();

  // ----------------------------------------------------------------
  // Strobe pin synchroniser
  // ----------------------------------------------------------------
  strobe_sync u_strobe_sync (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_strobe_pin_in),
    .rise_out(strobe_rise),
    .fall_out(strobe_fall)
  );

  // Only the rising edge moves data; the falling edge is left unused

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Master clocking is not built; clock_source_select at 1 leaves it idle.
  assign tx_active = tx_ctrl_ff[sst_pkg::TX_LOCKSTEP]
    & ~tx_ctrl_ff[sst_pkg::TX_CLOCK_SOURCE]
    & ~rx_ctrl_ff[sst_pkg::RX_SINGLE_RECEIVE]
    & ~rx_ctrl_ff[sst_pkg::RX_CONT_RECEIVE]
    & rx_ctrl_ff[sst_pkg::RX_PORT_ENABLE]
    & tx_ctrl_ff[sst_pkg::TX_ENABLE];

  // ----------------------------------------------------------------
  // Holding path: bus write, FIFO, holding register
  // ----------------------------------------------------------------
  assign hold_write = reg_wr_in & (reg_addr_in == sst_pkg::ADDR_HOLD);
  assign push_if.valid = hold_write;
  // Ninth bit is taken from the control register at the moment of the data write
  assign push_if.data = {tx_ctrl_ff[sst_pkg::TX_NINTH_VALUE], reg_wdata_in};
  assign hold_ready_out = push_if.ready;

  tx_fifo #(
    .WIDTH(sst_pkg::WORD_W),
    .DEPTH(sst_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .push(push_if.sink),
    .pop(pop_if.source)
  );

  assign last_bit = (state_ff == ST_SHIFT) & strobe_rise
    & (bits_left_ff == sst_pkg::CNT_W'(1));
  assign move_to_shift = hold_full_ff & tx_active
    & ((state_ff == ST_IDLE) | last_bit);
  assign hold_load = pop_if.valid & (~hold_full_ff | move_to_shift);
  assign pop_if.ready = ~hold_full_ff | move_to_shift;
  // Flag sets only when no other word waits behind the one that moves
  assign flag_set = move_to_shift & (queued_ff == sst_pkg::CNT_W'(1));

  // Words taken but not yet shifting; the FIFO delay must not look like an empty holding stage
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      queued_ff <= '0;
    end else begin
      queued_ff <= queued_ff + sst_pkg::CNT_W'(push_if.valid & push_if.ready)
        - sst_pkg::CNT_W'(move_to_shift);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_ff <= '0;
      hold_full_ff <= 1'b0;
    end else if (hold_load) begin
      hold_ff <= pop_if.data;
      hold_full_ff <= 1'b1;
    end else if (move_to_shift) begin
      hold_full_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shift register, advanced on strobe edges
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (move_to_shift) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!tx_active) begin
          nxt_state = ST_IDLE;
        end else if (last_bit && !move_to_shift) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_ff <= sst_pkg::SHIFT_IDLE;
      bits_left_ff <= '0;
      ninth_len_ff <= 1'b0;
    end else if (move_to_shift) begin
      // Word length is fixed when the word enters the shift register
      ninth_len_ff <= tx_ctrl_ff[sst_pkg::TX_NINTH_ENABLE];
      shift_ff <= tx_ctrl_ff[sst_pkg::TX_NINTH_ENABLE] ? hold_ff
        : {1'b1, hold_ff[sst_pkg::DATA_W-1:0]};
      bits_left_ff <= tx_ctrl_ff[sst_pkg::TX_NINTH_ENABLE]
        ? sst_pkg::BITS_NINE : sst_pkg::BITS_EIGHT;
    end else if (!tx_active) begin
      shift_ff <= sst_pkg::SHIFT_IDLE;
      bits_left_ff <= '0;
    end else if ((state_ff == ST_SHIFT) && strobe_rise) begin
      // LSB first; each external strobe rising edge moves the next bit out
      shift_ff <= {1'b1, shift_ff[sst_pkg::WORD_W-1:1]};
      bits_left_ff <= bits_left_ff - 1'b1;
    end
  end

  assign serial_data_out = shift_ff[0];
  assign serial_data_oe_out = tx_active;

  // ----------------------------------------------------------------
  // Transmit buffer flag, Sleep and wake-up
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buffer_flag_ff <= sst_pkg::RST_BUFFER_FLAG;
    end else if (flag_set) begin
      buffer_flag_ff <= 1'b1;
    end else if (hold_write) begin
      buffer_flag_ff <= 1'b0;
    end
  end

  assign wake_now = flag_set & sleep_ff & tx_irq_en_ff & periph_irq_en_ff;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sleep_ff <= 1'b0;
    end else if (wake_now) begin
      sleep_ff <= 1'b0;
    end else if (reg_wr_in && (reg_addr_in == sst_pkg::ADDR_WAKE)) begin
      sleep_ff <= reg_wdata_in[sst_pkg::WK_SLEEP];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_ff <= 1'b0;
      isr_ff <= 1'b0;
    end else begin
      wake_ff <= wake_now;
      isr_ff <= wake_now & global_irq_en_ff;
    end
  end

  assign wake_out = wake_ff;
  assign isr_branch_out = isr_ff;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_ctrl_ff <= sst_pkg::RST_TX_CTRL;
      rx_ctrl_ff <= sst_pkg::RST_RX_CTRL;
    end else if (reg_wr_in) begin
      if (reg_addr_in == sst_pkg::ADDR_TX_CTRL) begin
        tx_ctrl_ff <= reg_wdata_in;
      end
      if (reg_addr_in == sst_pkg::ADDR_RX_CTRL) begin
        rx_ctrl_ff <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_irq_en_ff <= 1'b0;
      periph_irq_en_ff <= 1'b0;
      global_irq_en_ff <= 1'b0;
    end else if (reg_wr_in && (reg_addr_in == sst_pkg::ADDR_WAKE)) begin
      tx_irq_en_ff <= reg_wdata_in[sst_pkg::WK_TX_IRQ_EN];
      periph_irq_en_ff <= reg_wdata_in[sst_pkg::WK_PERIPH_IRQ_EN];
      global_irq_en_ff <= reg_wdata_in[sst_pkg::WK_GLOBAL_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        sst_pkg::ADDR_TX_CTRL: begin
          rdata_ff <= tx_ctrl_ff;
          rdata_ff[sst_pkg::TX_SHIFT_EMPTY] <= (state_ff == ST_IDLE);
        end
        sst_pkg::ADDR_RX_CTRL: begin
          rdata_ff <= rx_ctrl_ff;
        end
        sst_pkg::ADDR_HOLD: begin
          rdata_ff <= hold_ff[sst_pkg::DATA_W-1:0];
        end
        sst_pkg::ADDR_WAKE: begin
          rdata_ff <= '0;
          rdata_ff[sst_pkg::WK_BUFFER_FLAG] <= buffer_flag_ff;
          rdata_ff[sst_pkg::WK_TX_IRQ_EN] <= tx_irq_en_ff;
          rdata_ff[sst_pkg::WK_PERIPH_IRQ_EN] <= periph_irq_en_ff;
          rdata_ff[sst_pkg::WK_GLOBAL_IRQ_EN] <= global_irq_en_ff;
          rdata_ff[sst_pkg::WK_SLEEP] <= sleep_ff;
          rdata_ff[sst_pkg::WK_FIFO_READY] <= push_if.ready;
        end
      endcase
    end else begin
      // Read data stand only in the cycle after the read strobe
      rdata_ff <= '0;
    end
  end

  assign reg_rdata_out = rdata_ff;

  logic unused_fall;
  assign unused_fall = strobe_fall;
endmodule : sync_slave_serial_transmit
`default_nettype wire

// File: common/sst_pkg.sv
package sst_pkg;
  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int WORD_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_HOLD = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_WAKE = 2'h3;

  // ----------------------------------------------------------------
  // Field positions: transmit_status_control
  // ----------------------------------------------------------------
  localparam int TX_NINTH_VALUE = 0;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_LOCKSTEP = 4;
  localparam int TX_ENABLE = 5;
  localparam int TX_NINTH_ENABLE = 6;
  localparam int TX_CLOCK_SOURCE = 7;

  // ----------------------------------------------------------------
  // Field positions: receive_status_control
  // ----------------------------------------------------------------
  localparam int RX_CONT_RECEIVE = 4;
  localparam int RX_SINGLE_RECEIVE = 5;
  localparam int RX_PORT_ENABLE = 7;

  // ----------------------------------------------------------------
  // Field positions: wake control and status
  // ----------------------------------------------------------------
  localparam int WK_BUFFER_FLAG = 0;
  localparam int WK_TX_IRQ_EN = 1;
  localparam int WK_PERIPH_IRQ_EN = 2;
  localparam int WK_GLOBAL_IRQ_EN = 3;
  localparam int WK_SLEEP = 4;
  localparam int WK_FIFO_READY = 5;

  // ----------------------------------------------------------------
  // Reset values and word lengths
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_TX_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_RX_CTRL = 8'h00;
  localparam logic RST_BUFFER_FLAG = 1'b1;
  localparam logic [WORD_W-1:0] SHIFT_IDLE = 9'h1ff;
  localparam logic [CNT_W-1:0] BITS_EIGHT = 4'h8;
  localparam logic [CNT_W-1:0] BITS_NINE = 4'h9;
endpackage : sst_pkg

// File: common/stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// File: rtl/strobe_sync.sv
`timescale 1ns/1ps
`default_nettype none
module strobe_sync (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic rise_out,
  output logic fall_out
);
  // ----------------------------------------------------------------
  // Two-stage synchroniser, edge taken between stages two and three
  // ----------------------------------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise_out = sync_ff & ~last_ff;
  assign fall_out = ~sync_ff & last_ff;
endmodule : strobe_sync
`default_nettype wire

// File: rtl/tx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  stream_if.sink push,
  stream_if.source pop
);
  // ----------------------------------------------------------------
  // Storage array plus a registered output word
  // ----------------------------------------------------------------
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic do_push;
  logic do_fetch;

  assign push.ready = (count_ff != (PTR_W+1)'(DEPTH));
  assign do_push = push.valid & push.ready;
  // Refill the output word when it is empty or being taken
  assign do_fetch = (count_ff != '0) & (~out_valid_ff | pop.ready);
  assign pop.valid = out_valid_ff;
  assign pop.data = out_data_ff;

  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= push.data;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_fetch) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_fetch);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (do_fetch) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (pop.ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule : tx_fifo
`default_nettype wire

// File: dv/sst_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sst_monitor (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [sst_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [sst_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [sst_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic hold_ready_out,
  input wire logic serial_strobe_pin_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_out,
  input wire logic wake_out,
  input wire logic isr_branch_out
);
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic [7:0] wk_ff;
  logic strobe_q_ff;
  logic [3:0] quiet_ff;
  logic active;
  logic hold_ok;
  logic rd_wake;
  assign hold_ok = reg_wr_in && reg_addr_in == sst_pkg::ADDR_HOLD && hold_ready_out;
  assign rd_wake = reg_rd_in && reg_addr_in == sst_pkg::ADDR_WAKE;
  assign active = tx_ff[sst_pkg::TX_LOCKSTEP] && !tx_ff[sst_pkg::TX_CLOCK_SOURCE]
    && tx_ff[sst_pkg::TX_ENABLE] && rx_ff[sst_pkg::RX_PORT_ENABLE]
    && !rx_ff[sst_pkg::RX_SINGLE_RECEIVE] && !rx_ff[sst_pkg::RX_CONT_RECEIVE];
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_ff <= sst_pkg::RST_TX_CTRL;
      rx_ff <= sst_pkg::RST_RX_CTRL;
    end else if (reg_wr_in) begin
      if (reg_addr_in == sst_pkg::ADDR_TX_CTRL) tx_ff <= reg_wdata_in;
      if (reg_addr_in == sst_pkg::ADDR_RX_CTRL) rx_ff <= reg_wdata_in;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) wk_ff <= 8'h00;
    else if (reg_wr_in && reg_addr_in == sst_pkg::ADDR_WAKE) wk_ff <= reg_wdata_in;
    else if (wake_out) wk_ff[sst_pkg::WK_SLEEP] <= 1'b0;
  end
  // Data may only move a few cycles after a strobe rise or a register write
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strobe_q_ff <= 1'b1;
      quiet_ff <= 4'h0;
    end else begin
      strobe_q_ff <= serial_strobe_pin_in;
      if (reg_wr_in || (serial_strobe_pin_in && !strobe_q_ff)) quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_oe_mode;
    serial_data_oe_out == active;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("oe disagrees with mode");
  property p_idle_high;
    !serial_data_oe_out && !$past(serial_data_oe_out) |-> serial_data_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data not idle high");
  property p_quiet;
    quiet_ff >= 4'h6 |-> $stable(serial_data_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("data moved without strobe");
  property p_wake_pulse;
    wake_out |=> !wake_out;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  property p_wake_cause;
    wake_out |-> wk_ff[sst_pkg::WK_SLEEP] && wk_ff[sst_pkg::WK_TX_IRQ_EN]
      && wk_ff[sst_pkg::WK_PERIPH_IRQ_EN];
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake not enabled");
  property p_isr;
    wake_out || isr_branch_out |-> wake_out && isr_branch_out == wk_ff[sst_pkg::WK_GLOBAL_IRQ_EN];
  endproperty
  a_isr: assert property (p_isr) else $error("branch pulse wrong");
  property p_ready_fall;
    $fell(hold_ready_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == sst_pkg::ADDR_HOLD;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready fell unprompted");
  property p_flag_clear;
    $past(hold_ok, 3) && $past(rd_wake) |-> !reg_rdata_out[sst_pkg::WK_BUFFER_FLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
endmodule : sst_monitor
bind sync_slave_serial_transmit sst_monitor u_sst_monitor (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .hold_ready_out(hold_ready_out),
  .serial_strobe_pin_in(serial_strobe_pin_in), .serial_data_out(serial_data_out),
  .serial_data_oe_out(serial_data_oe_out), .wake_out(wake_out),
  .isr_branch_out(isr_branch_out));
`default_nettype wire

// File: dv/sync_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_master_model (
  output logic strobe_out,
  input wire logic data_in,
  input wire logic oe_in
);
  logic [8:0] word_seen;
  // Strobe rests high between frames, so the slave sees no stray edge
  initial strobe_out = 1'b1;
  // Short low phase, long high phase: the slave needs up to 3 cycles after a rise
  task automatic clock_word(input int nbits, input bit slow);
    word_seen = 9'h000;
    #13;
    for (int i = 0; i < nbits; i++) begin
      strobe_out = 1'b0;
      word_seen[i] = oe_in ? data_in : 1'bx;
      #40 strobe_out = 1'b1;
      #(slow ? 600 : 120);
    end
  endtask : clock_word
endmodule : sync_master_model
`default_nettype wire

// File: dv/tb_sync_slave_serial_transmit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_slave_serial_transmit;
  logic mclk_in;
  logic rst_b_in;
  logic [sst_pkg::ADDR_W-1:0] reg_addr_in;
  logic [sst_pkg::DATA_W-1:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [sst_pkg::DATA_W-1:0] reg_rdata_out;
  logic hold_ready_out;
  logic strobe;
  logic serial_data_out;
  logic serial_data_oe_out;
  logic wake_out;
  logic isr_branch_out;
  int err_count = 0;
  int checks = 0;
  int wake_cnt = 0;
  int isr_cnt = 0;
  int n;
  logic [16:0] cfg [7] = '{{8'h10, 8'h80, 1'b0}, {8'h20, 8'h80, 1'b0}, {8'hb0, 8'h80, 1'b0},
    {8'h30, 8'h00, 1'b0}, {8'h30, 8'ha0, 1'b0}, {8'h30, 8'h90, 1'b0}, {8'h30, 8'h80, 1'b1}};
  sync_slave_serial_transmit u_sync_slave_serial_transmit (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .hold_ready_out(hold_ready_out),
    .serial_strobe_pin_in(strobe), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .wake_out(wake_out),
    .isr_branch_out(isr_branch_out));
  sync_master_model u_sync_master_model (
    .strobe_out(strobe), .data_in(serial_data_out), .oe_in(serial_data_oe_out));
  initial mclk_in = 1'b0;
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (wake_out === 1'b1) wake_cnt++;
    if (isr_branch_out === 1'b1) isr_cnt++;
  end
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(what, {1'b0, reg_rdata_out & m}, {1'b0, exp});
  endtask : rd_chk
  task automatic word_chk(input int nbits, input bit slow, input logic [8:0] exp);
    repeat (8) @(posedge mclk_in);
    u_sync_master_model.clock_word(nbits, slow);
    check("word", u_sync_master_model.word_seen, exp);
  endtask : word_chk
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'b0;
    reg_addr_in = 2'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd_chk("tx_ctrl", sst_pkg::ADDR_TX_CTRL, 8'hfd, sst_pkg::RST_TX_CTRL);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, {7'h00, sst_pkg::RST_BUFFER_FLAG});
    // Set-up order: mode and transmit enable, then port enable last
    foreach (cfg[i]) begin
      wr(sst_pkg::ADDR_TX_CTRL, cfg[i][16:9]);
      wr(sst_pkg::ADDR_RX_CTRL, cfg[i][8:1]);
      #1;
      check("oe", serial_data_oe_out, cfg[i][0]);
      check("idle", serial_data_out, 1'b1);
    end
    rd_chk("rx_ctrl", sst_pkg::ADDR_RX_CTRL, 8'hff, 8'h80);
    wr(sst_pkg::ADDR_HOLD, 8'ha5);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, 8'h00);
    word_chk(8, 1'b0, 9'h0a5);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(sst_pkg::ADDR_TX_CTRL, i ? 8'h71 : 8'h70);
      wr(sst_pkg::ADDR_HOLD, i ? 8'h3c : 8'hc3);
      word_chk(9, 1'b1, i ? 9'h13c : 9'h0c3);
    end
    wr(sst_pkg::ADDR_TX_CTRL, 8'h30);
    wr(sst_pkg::ADDR_HOLD, 8'h11);
    wr(sst_pkg::ADDR_HOLD, 8'h22);
    wr(sst_pkg::ADDR_WAKE, 8'h1e);
    repeat (10) @(posedge mclk_in);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, 8'h00);
    check("wake", wake_cnt[8:0], 9'h000);
    rd_chk("empty", sst_pkg::ADDR_TX_CTRL, 8'h02, 8'h00);
    word_chk(8, 1'b0, 9'h011);
    repeat (8) @(posedge mclk_in);
    check("wake", wake_cnt[8:0], 9'h001);
    check("isr", isr_cnt[8:0], 9'h001);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, 8'h01);
    rd_chk("sleep", sst_pkg::ADDR_WAKE, 8'h1e, 8'h0e);
    word_chk(8, 1'b0, 9'h022);
    wr(sst_pkg::ADDR_WAKE, 8'h16);
    wr(sst_pkg::ADDR_HOLD, 8'h33);
    repeat (10) @(posedge mclk_in);
    check("wake", wake_cnt[8:0], 9'h002);
    check("isr", isr_cnt[8:0], 9'h001);
    word_chk(8, 1'b0, 9'h033);
    // Transmit off: words pile up until the queue refuses
    wr(sst_pkg::ADDR_TX_CTRL, 8'h10);
    n = 0;
    while (hold_ready_out === 1'b1 && n < 12) begin
      wr(sst_pkg::ADDR_HOLD, 8'h40 + n[7:0]);
      repeat (4) @(posedge mclk_in);
      #1;
      n++;
    end
    check("depth", n[8:0], 9'(sst_pkg::FIFO_DEPTH + 2));
    wr(sst_pkg::ADDR_HOLD, 8'hee);
    #1;
    check("idle", serial_data_out, 1'b1);
    rd_chk("ready", sst_pkg::ADDR_WAKE, 8'h20, 8'h00);
    rd_chk("hold", sst_pkg::ADDR_HOLD, 8'hff, 8'h40);
    wr(sst_pkg::ADDR_TX_CTRL, 8'h30);
    for (int i = 0; i < sst_pkg::FIFO_DEPTH + 2; i++) begin
      word_chk(8, i[0], 9'h040 + i[8:0]);
    end
    repeat (8) @(posedge mclk_in);
    rd_chk("flag", sst_pkg::ADDR_WAKE, 8'h01, 8'h01);
    rd_chk("empty", sst_pkg::ADDR_TX_CTRL, 8'h02, 8'h02);
    test_done();
  end
endmodule : tb_sync_slave_serial_transmit
`default_nettype wire
